// file: logic/fpd_pkg.sv
// package of constants for the fail-safe passivation and diagnostics block
package fpd_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 10;
  localparam int WD_W = 16;
  localparam logic [7:0] CODE_SHORT = 8'h01;
  localparam logic [7:0] CODE_CONFIG = 8'h10;
  localparam logic [7:0] CODE_COMM = 8'h13;
  localparam logic [7:0] CODE_DISCREP = 8'h19;
  localparam logic [7:0] CODE_SENSOR = 8'h1C;
  localparam logic [7:0] CODE_ADDR = 8'h1D;
  localparam logic [7:0] CODE_SERIOUS = 8'h1E;
  localparam logic [7:0] CODE_VERSION = 8'h1F;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [1:0] CH_NONE = 2'h0;
  localparam logic [WD_W-1:0] WD_MIN = 16'h000A;
  localparam logic [WD_W-1:0] WD_RST = 16'h0000;
  localparam logic [1:0] EVAL_OFF = 2'h0;
  localparam logic [1:0] EVAL_1OO1 = 2'h1;
  localparam logic [1:0] EVAL_1OO2 = 2'h2;
  localparam logic [1:0] EVAL_BAD = 2'h3;
  localparam logic [31:0] WB_ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] WB_ADDR_CFG = 32'h0000_0004;
  localparam logic [31:0] WB_ADDR_STAT = 32'h0000_0008;
  localparam logic [31:0] WB_ADDR_SAFETY_WORD_A = 32'h0000_000C;
  localparam logic [31:0] WB_ADDR_WD = 32'h0000_0010;
  localparam logic [31:0] WB_ADDR_DATA = 32'h0000_0014;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam int CFG_ADDR_LSB = 0;
  localparam int CFG_EVAL01_LSB = 16;
  localparam int CFG_EVAL23_LSB = 18;
  localparam int CFG_VALID_BIT = 20;
  localparam int CTRL_REINT_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;
  localparam int CTRL_ACKREQ_BIT = 2;
  typedef enum logic [1:0] {
    ST_PASSIVE = 2'b00,
    ST_WAIT_ACK = 2'b01,
    ST_ACTIVE = 2'b10,
    ST_DEAD = 2'b11
  } fpd_state_t;
endpackage : fpd_pkg

// file: logic/fpd_top.sv
// fail-safe passivation, diagnostic reporting and reintegration with a wishbone slave
`timescale 1ns/1ns
module fpd_top (
  // clock and reset
  input  wire logic                          MCLK_IN,
  input  wire logic                          SYS_RST_IN,
  // wishbone slave
  input  wire logic                          WB_CYC_IN,
  input  wire logic                          WB_STB_IN,
  input  wire logic                          WB_WE_IN,
  input  wire logic [31:0]                   WB_ADR_IN,
  input  wire logic [3:0]                    WB_SEL_IN,
  input  wire logic [31:0]                   WB_DAT_IN,
  output logic [31:0]                        WB_DAT_OUT,
  output logic                               WB_ACK_OUT,
  // process inputs and fault sources
  input  wire logic [fpd_pkg::NUM_CH-1:0]    CH_RAW_IN,
  input  wire logic [fpd_pkg::NUM_CH-1:0]    CH_SHORT_IN,
  input  wire logic [fpd_pkg::ADDR_W-1:0]    LOCAL_ADDR_IN,
  input  wire logic                          COMM_OK_IN,
  input  wire logic                          FW_MISMATCH_IN,
  input  wire logic                          INTERNAL_ERR_IN,
  input  wire logic                          SERIOUS_ERR_IN,
  // safety outputs
  output logic [fpd_pkg::NUM_CH-1:0]         CH_VALUE_OUT,
  output logic                               PASSIVE_OUT,
  output logic                               LINK_EN_OUT,
  output logic                               SAFETY_WORD_A_VALID_OUT,
  output logic [7:0]                         SAFETY_WORD_A_CODE_OUT,
  output logic [1:0]                         SAFETY_WORD_A_CHAN_OUT,
  output logic                               SAFETY_WORD_A_CHAN_SCOPE_OUT
);
  import fpd_pkg::*;

  typedef struct packed {
    fpd_state_t           state;
    logic [31:0]          cfg;
    logic [WD_W-1:0]      wd_time;
    logic [WD_W-1:0]      wd_cnt;
    logic                 ack_req;
    logic                 fault_seen;
    logic [7:0]           code;
    logic [1:0]           chan;
    logic                 chan_scope;
    logic                 safety_word_a_valid;
    logic [NUM_CH-1:0]    values;
    logic                 wb_ack;
    logic [31:0]          rdata;
  } fpd_regs_t;

  fpd_regs_t r_reg;
  fpd_regs_t r_next;

  logic              wb_req;
  logic              wr_ctrl;
  logic              reint_req;
  logic              ack_pulse;
  logic [1:0]        eval01;
  logic [1:0]        eval23;
  logic [NUM_CH-1:0] discrep;
  logic              wd_expired;
  logic              f_short;
  logic              f_config;
  logic              f_comm;
  logic              f_discrep;
  logic              f_sensor;
  logic              f_addr;
  logic              f_version;
  logic              any_fault;
  logic [7:0]        pick_code;
  logic [1:0]        pick_chan;
  logic              pick_scope;
  logic [31:0]       wd_merged;

  function automatic logic [1:0] first_bit(input logic [NUM_CH-1:0] v);
    logic [1:0] idx;
    idx = CH_NONE;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : first_bit

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign wb_req = WB_CYC_IN && WB_STB_IN && !r_reg.wb_ack;
  assign wr_ctrl = wb_req && WB_WE_IN && (WB_ADR_IN == WB_ADDR_CTRL) && WB_SEL_IN[0];
  assign reint_req = wr_ctrl && WB_DAT_IN[CTRL_REINT_BIT];
  assign ack_pulse = wr_ctrl && WB_DAT_IN[CTRL_ACK_BIT];
  assign eval01 = r_reg.cfg[CFG_EVAL01_LSB +: 2];
  assign eval23 = r_reg.cfg[CFG_EVAL23_LSB +: 2];
  assign wd_merged = merge({16'h0000, r_reg.wd_time}, WB_DAT_IN, WB_SEL_IN);

  // two-channel pairs must agree
  assign discrep[0] = (eval01 == EVAL_1OO2) && (CH_RAW_IN[0] != CH_RAW_IN[1]);
  assign discrep[1] = 1'b0;
  assign discrep[2] = (eval23 == EVAL_1OO2) && (CH_RAW_IN[2] != CH_RAW_IN[3]);
  assign discrep[3] = 1'b0;

  assign wd_expired = (r_reg.wd_time < WD_MIN) || (r_reg.wd_cnt >= r_reg.wd_time);
  assign f_short = |CH_SHORT_IN || INTERNAL_ERR_IN;
  assign f_discrep = |discrep;
  assign f_config = !r_reg.cfg[CFG_VALID_BIT];
  assign f_comm = !COMM_OK_IN || wd_expired;
  assign f_sensor = (eval01 == EVAL_BAD) || (eval23 == EVAL_BAD);
  assign f_addr = LOCAL_ADDR_IN != r_reg.cfg[CFG_ADDR_LSB +: ADDR_W];
  assign f_version = FW_MISMATCH_IN;
  assign any_fault = f_short || f_discrep || f_config || f_comm || f_sensor || f_addr || f_version;

  // one diagnosis chosen by fixed priority
  always_comb begin
    pick_code = CODE_NONE;
    pick_chan = CH_NONE;
    pick_scope = 1'b0;
    if (f_version) begin
      pick_code = CODE_VERSION;
    end else if (f_sensor) begin
      pick_code = CODE_SENSOR;
    end else if (f_addr) begin
      pick_code = CODE_ADDR;
    end else if (f_config) begin
      pick_code = CODE_CONFIG;
    end else if (f_comm) begin
      pick_code = CODE_COMM;
    end else if (f_short) begin
      pick_code = CODE_SHORT;
      pick_chan = first_bit(CH_SHORT_IN);
      pick_scope = 1'b1;
    end else if (f_discrep) begin
      pick_code = CODE_DISCREP;
      pick_chan = first_bit(discrep);
      pick_scope = 1'b1;
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.wb_ack = wb_req;
    r_next.safety_word_a_valid = 1'b0;
    if (wb_req && WB_WE_IN) begin
      case (WB_ADR_IN)
        WB_ADDR_CFG: begin
          r_next.cfg = merge(r_reg.cfg, WB_DAT_IN, WB_SEL_IN);
        end
        WB_ADDR_WD: begin
          r_next.wd_time = wd_merged[WD_W-1:0];
        end
        WB_ADDR_CTRL: begin
          if (WB_SEL_IN[0]) begin
            r_next.ack_req = WB_DAT_IN[CTRL_ACKREQ_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // watchdog restarts on every good telegram
    if (!COMM_OK_IN || (wb_req && WB_WE_IN && (WB_ADR_IN == WB_ADDR_DATA))) begin
      r_next.wd_cnt = WD_RST;
    end else if (r_reg.wd_cnt != {WD_W{1'b1}}) begin
      r_next.wd_cnt = r_reg.wd_cnt + 16'h0001;
    end
    case (r_reg.state)
      ST_PASSIVE: begin
        if (reint_req && !any_fault) begin
          r_next.state = r_reg.ack_req ? ST_WAIT_ACK : ST_ACTIVE;
          r_next.fault_seen = 1'b0;
        end
      end
      ST_WAIT_ACK: begin
        if (any_fault) begin
          r_next.state = ST_PASSIVE;
        end else if (ack_pulse) begin
          r_next.state = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (any_fault) begin
          r_next.state = ST_PASSIVE;
        end
      end
      ST_DEAD: begin
        r_next.state = ST_DEAD;
      end
      default: begin
        r_next.state = ST_PASSIVE;
      end
    endcase
    // report once per passivation, unasked
    if (any_fault && !r_reg.fault_seen && r_reg.state != ST_DEAD) begin
      r_next.fault_seen = 1'b1;
      r_next.code = pick_code;
      r_next.chan = pick_chan;
      r_next.chan_scope = pick_scope;
      r_next.safety_word_a_valid = 1'b1;
    end
    if (SERIOUS_ERR_IN) begin
      r_next.state = ST_DEAD;
      r_next.safety_word_a_valid = 1'b0;
      r_next.code = CODE_SERIOUS;
    end
    r_next.values = (r_next.state == ST_ACTIVE) ? CH_RAW_IN : '0;
    r_next.rdata = 32'h0000_0000;
    if (wb_req && !WB_WE_IN) begin
      case (WB_ADR_IN)
        WB_ADDR_CTRL: begin
          r_next.rdata = {29'h0, r_reg.ack_req, 2'b00};
        end
        WB_ADDR_CFG: begin
          r_next.rdata = r_reg.cfg;
        end
        WB_ADDR_STAT: begin
          r_next.rdata = {24'h0, r_reg.state, f_comm, any_fault, 3'b000,
                          (r_reg.state != ST_ACTIVE)};
        end
        WB_ADDR_SAFETY_WORD_A: begin
          r_next.rdata = {21'h0, r_reg.chan_scope, r_reg.chan, r_reg.code};
        end
        WB_ADDR_WD: begin
          r_next.rdata = {16'h0, r_reg.wd_time};
        end
        WB_ADDR_DATA: begin
          r_next.rdata = {28'h0, r_reg.values};
        end
        default: begin
          r_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      r_reg <= '{state: ST_PASSIVE, cfg: CFG_RST, wd_time: WD_RST, wd_cnt: WD_RST,
                 ack_req: 1'b0, fault_seen: 1'b0, code: CODE_NONE, chan: CH_NONE,
                 chan_scope: 1'b0, safety_word_a_valid: 1'b0, values: '0, wb_ack: 1'b0,
                 rdata: 32'h0000_0000};
    end else begin
      r_reg <= r_next;
    end
  end

  assign WB_ACK_OUT = r_reg.wb_ack;
  assign WB_DAT_OUT = r_reg.rdata;
  assign CH_VALUE_OUT = r_reg.values;
  assign PASSIVE_OUT = r_reg.state != ST_ACTIVE;
  assign LINK_EN_OUT = r_reg.state != ST_DEAD;
  assign SAFETY_WORD_A_VALID_OUT = r_reg.safety_word_a_valid;
  assign SAFETY_WORD_A_CODE_OUT = r_reg.code;
  assign SAFETY_WORD_A_CHAN_OUT = r_reg.chan;
  assign SAFETY_WORD_A_CHAN_SCOPE_OUT = r_reg.chan_scope;

  property p_zero_when_passive;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) PASSIVE_OUT |-> CH_VALUE_OUT == '0;
  endproperty
  a_zero_when_passive: assert property (p_zero_when_passive) else $error("values not zero while passive");

  property p_fault_passivates;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) (r_reg.state == ST_ACTIVE && any_fault) |=> PASSIVE_OUT;
  endproperty
  a_fault_passivates: assert property (p_fault_passivates) else $error("fault did not passivate");

  property p_live_values;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) (r_next.state == ST_ACTIVE) |=> CH_VALUE_OUT == $past(CH_RAW_IN);
  endproperty
  a_live_values: assert property (p_live_values) else $error("live values missing when active");

  property p_dead_silent;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) $past(SERIOUS_ERR_IN) |-> !SAFETY_WORD_A_VALID_OUT && !LINK_EN_OUT;
  endproperty
  a_dead_silent: assert property (p_dead_silent) else $error("serious error left link or safety_word_a on");

  property p_safety_word_a_on_fault;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN)
      (!SYS_RST_IN && any_fault && !r_reg.fault_seen && !SERIOUS_ERR_IN && r_reg.state != ST_DEAD) |=> SAFETY_WORD_A_VALID_OUT;
  endproperty
  a_safety_word_a_on_fault: assert property (p_safety_word_a_on_fault) else $error("fault not reported");

  property p_comm_code;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) SAFETY_WORD_A_VALID_OUT && SAFETY_WORD_A_CODE_OUT == CODE_COMM |-> !SAFETY_WORD_A_CHAN_SCOPE_OUT;
  endproperty
  a_comm_code: assert property (p_comm_code) else $error("comm error flagged as channel scope");

  property p_short_code;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) SAFETY_WORD_A_VALID_OUT && SAFETY_WORD_A_CHAN_SCOPE_OUT |->
      (SAFETY_WORD_A_CODE_OUT == CODE_SHORT || SAFETY_WORD_A_CODE_OUT == CODE_DISCREP);
  endproperty
  a_short_code: assert property (p_short_code) else $error("bad channel diagnostic code");

  property p_hold_passive;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) (PASSIVE_OUT && !reint_req && !ack_pulse) |=> PASSIVE_OUT;
  endproperty
  a_hold_passive: assert property (p_hold_passive) else $error("left passive without reintegration");

  property p_single_report;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) SAFETY_WORD_A_VALID_OUT |=> !SAFETY_WORD_A_VALID_OUT;
  endproperty
  a_single_report: assert property (p_single_report) else $error("diagnostic repeated");

  property p_clean_active;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) !PASSIVE_OUT |-> !$past(any_fault);
  endproperty
  a_clean_active: assert property (p_clean_active) else $error("active right after a fault");

  property p_report_passive;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) SAFETY_WORD_A_VALID_OUT |-> PASSIVE_OUT;
  endproperty
  a_report_passive: assert property (p_report_passive) else $error("report while not passive");

  property p_report_cause;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) SAFETY_WORD_A_VALID_OUT |-> $past(any_fault);
  endproperty
  a_report_cause: assert property (p_report_cause) else $error("report without a fault");

  property p_addr_passivates;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) (!PASSIVE_OUT && f_addr) |=> PASSIVE_OUT;
  endproperty
  a_addr_passivates: assert property (p_addr_passivates) else $error("address mismatch did not passivate");

  property p_serious_code;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) $past(SERIOUS_ERR_IN) |-> SAFETY_WORD_A_CODE_OUT == CODE_SERIOUS;
  endproperty
  a_serious_code: assert property (p_serious_code) else $error("serious error code missing");

  property p_dead_stays;
    @(posedge MCLK_IN) disable iff (SYS_RST_IN) !LINK_EN_OUT |=> !LINK_EN_OUT;
  endproperty
  a_dead_stays: assert property (p_dead_stays) else $error("link came back without reset");

  c_reint: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) PASSIVE_OUT ##1 !PASSIVE_OUT);
  c_wait_ack: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) r_reg.state == ST_WAIT_ACK ##1 !PASSIVE_OUT);
  c_discrep: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) SAFETY_WORD_A_VALID_OUT && SAFETY_WORD_A_CODE_OUT == CODE_DISCREP);
  c_dead: cover property (@(posedge MCLK_IN) disable iff (SYS_RST_IN) !LINK_EN_OUT);
endmodule : fpd_top

// file: tb/fpd_ctrl_model.sv
// controller-side model that logs unsolicited diagnostic reports
`timescale 1ns/1ns
module fpd_ctrl_model (
  // clock
  input  wire logic       clk_in,
  // diagnostic report from the device
  input  wire logic       safety_word_a_valid_in,
  input  wire logic [7:0] safety_word_a_code_in,
  input  wire logic [1:0] safety_word_a_chan_in,
  input  wire logic       safety_word_a_scope_in,
  // logged view
  output int              n_safety_word_a_out,
  output logic [7:0]      last_code_out,
  output logic [1:0]      last_chan_out,
  output logic            last_scope_out
);
  // the log lives in the controller and survives device resets
  initial begin
    n_safety_word_a_out = 0;
    last_code_out = 8'h00;
    last_chan_out = 2'h0;
    last_scope_out = 1'b0;
  end
  always @(posedge clk_in) begin
    if (safety_word_a_valid_in === 1'b1) begin
      n_safety_word_a_out <= n_safety_word_a_out + 1;
      last_code_out <= safety_word_a_code_in;
      last_chan_out <= safety_word_a_chan_in;
      last_scope_out <= safety_word_a_scope_in;
    end
  end
endmodule : fpd_ctrl_model

// file: tb/failsafe_passivation_safety_word_a_bench.sv
// bench: passivation, diagnostics and reintegration through wishbone
`timescale 1ns/1ns
module failsafe_passivation_safety_word_a_bench;
  import fpd_pkg::*;
  localparam logic [31:0] CFG_OK = 32'h0015017F;
  logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, dout;
  logic [3:0] sel = 4'h0;
  logic [NUM_CH-1:0] raw = 4'hA, shrt = 4'h0, val;
  logic [ADDR_W-1:0] laddr = 10'h17F;
  logic comm = 1'b1, fw = 1'b0, interr = 1'b0, serr = 1'b0;
  logic ack, pas, link, dv, scope, lsc;
  logic [7:0] code, lc;
  logic [1:0] chan, lch;
  int n_mismatch = 0, total_checks = 0, nd, nd0;
  logic [7:0] exp_code [9] = '{CODE_SHORT, CODE_SHORT, CODE_DISCREP, CODE_COMM, CODE_VERSION,
                               CODE_ADDR, CODE_SENSOR, CODE_CONFIG, CODE_COMM};
  logic [1:0] exp_chan [9] = '{2'h2, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0};
  logic exp_sc [9] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  always #25 mclk = ~mclk;
  fpd_top fpd_top_i (.MCLK_IN(mclk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(dout), .WB_ACK_OUT(ack),
    .CH_RAW_IN(raw), .CH_SHORT_IN(shrt), .LOCAL_ADDR_IN(laddr), .COMM_OK_IN(comm), .FW_MISMATCH_IN(fw),
    .INTERNAL_ERR_IN(interr), .SERIOUS_ERR_IN(serr), .CH_VALUE_OUT(val), .PASSIVE_OUT(pas),
    .LINK_EN_OUT(link), .SAFETY_WORD_A_VALID_OUT(dv), .SAFETY_WORD_A_CODE_OUT(code), .SAFETY_WORD_A_CHAN_OUT(chan),
    .SAFETY_WORD_A_CHAN_SCOPE_OUT(scope));
  fpd_ctrl_model fpd_ctrl_model_i (.clk_in(mclk), .safety_word_a_valid_in(dv), .safety_word_a_code_in(code),
    .safety_word_a_chan_in(chan), .safety_word_a_scope_in(scope), .n_safety_word_a_out(nd), .last_code_out(lc),
    .last_chan_out(lch), .last_scope_out(lsc));
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    q = 32'h0;
    @(posedge mclk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    q = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb
  task reint(input logic need_ack);
    wb(1'b1, WB_ADDR_DATA, 32'h0, rdat);
    if (need_ack) begin
      wb(1'b1, WB_ADDR_CTRL, 32'h4, rdat);
      wb(1'b0, WB_ADDR_CTRL, 32'h0, rdat);
      chk("ack required", 32'h4, rdat);
      wb(1'b1, WB_ADDR_CTRL, 32'h1, rdat);
      repeat (3) @(negedge mclk);
      chk("wait for ack", 1, pas);
      wb(1'b1, WB_ADDR_CTRL, 32'h2, rdat);
    end else wb(1'b1, WB_ADDR_CTRL, 32'h1, rdat);
    repeat (3) @(negedge mclk);
    chk("passive after reint", 0, pas);
  endtask : reint
  task fault(input int k, input logic on);
    @(posedge mclk);
    case (k)
      0: shrt <= on ? 4'h4 : 4'h0;
      1: interr <= on;
      2: wb(1'b1, WB_ADDR_CFG, on ? 32'h0016017F : CFG_OK, rdat);
      3: comm <= !on;
      4: fw <= on;
      5: laddr <= on ? 10'h17E : 10'h17F;
      6: wb(1'b1, WB_ADDR_CFG, on ? 32'h001D017F : CFG_OK, rdat);
      7: wb(1'b1, WB_ADDR_CFG, on ? 32'h0005017F : CFG_OK, rdat);
      default: wb(1'b1, WB_ADDR_WD, on ? 32'h0000000C : 32'h0000FFFF, rdat);
    endcase
  endtask : fault
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("passive at power-on", 1, pas);
    chk("values at power-on", 0, val);
    chk("link", 1, link);
    chk("reports after reset", 1, nd);
    chk("reset code", CODE_ADDR, lc);
    wb(1'b0, WB_ADDR_STAT, 32'h0, rdat);
    chk("stat passive", 1, rdat[0]);
    wb(1'b0, 32'h0000_0040, 32'h0, rdat);
    chk("unmapped read", 0, rdat);
    wb(1'b1, WB_ADDR_WD, 32'h0000FFFF, rdat);
    wb(1'b1, WB_ADDR_CFG, CFG_OK, rdat);
    reint(1'b0);
    @(posedge mclk);
    raw <= 4'h5;
    repeat (2) @(negedge mclk);
    chk("live values", 4'h5, val);
    @(posedge mclk);
    raw <= 4'hA;
    $display("test startup done");
    for (int k = 0; k < 9; k++) begin
      nd0 = nd;
      fault(k, 1'b1);
      repeat (30) @(negedge mclk);
      chk("passive", 1, pas);
      chk("substitute", 0, val);
      chk("safety_word_a count", nd0 + 1, nd);
      chk("safety_word_a code", exp_code[k], lc);
      if (exp_sc[k]) chk("safety_word_a chan", exp_chan[k], lch);
      chk("safety_word_a scope", exp_sc[k], lsc);
      fault(k, 1'b0);
      repeat (5) @(negedge mclk);
      chk("held passive", 1, pas);
      chk("held zero", 0, val);
      reint(k == 3);
      chk("values back", raw, val);
      $display("test fault %0d done", k);
    end
    nd0 = nd;
    @(posedge mclk);
    serr <= 1'b1;
    repeat (5) @(negedge mclk);
    chk("link dropped", 0, link);
    chk("serious passive", 1, pas);
    chk("serious zero", 0, val);
    chk("no report", nd0, nd);
    $display("test serious done");
    nd0 = nd;
    @(posedge mclk);
    rst <= 1'b1;
    serr <= 1'b0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("link after restart", 1, link);
    chk("passive after restart", 1, pas);
    chk("one report after restart", nd0 + 1, nd);
    chk("restart code", CODE_ADDR, lc);
    $display("test restart done");
    print_verdict;
  end
endmodule : failsafe_passivation_safety_word_a_bench
